// ### rtl/tsrm_consts.svh
`ifndef TSRM_CONSTS_SVH
`define TSRM_CONSTS_SVH
// ----------------------------------------------------------------
// pointer codes
// ----------------------------------------------------------------
`define TSRM_PTR_LT_HI 8'h00
`define TSRM_PTR_RT_HI 8'h01
`define TSRM_PTR_FLAGS 8'h02
`define TSRM_PTR_SETUP_RD 8'h03
`define TSRM_PTR_RATE_RD 8'h04
`define TSRM_PTR_LUL_HI_RD 8'h05
`define TSRM_PTR_LLL_HI_RD 8'h06
`define TSRM_PTR_RUL_HI_RD 8'h07
`define TSRM_PTR_RLL_HI_RD 8'h08
`define TSRM_PTR_SETUP_WR 8'h09
`define TSRM_PTR_RATE_WR 8'h0a
`define TSRM_PTR_LUL_HI_WR 8'h0b
`define TSRM_PTR_LLL_HI_WR 8'h0c
`define TSRM_PTR_RUL_HI_WR 8'h0d
`define TSRM_PTR_RLL_HI_WR 8'h0e
`define TSRM_PTR_ONESHOT 8'h0f
`define TSRM_PTR_RT_LO 8'h10
`define TSRM_PTR_RUL_LO 8'h13
`define TSRM_PTR_RLL_LO 8'h14
`define TSRM_PTR_LT_LO 8'h15
`define TSRM_PTR_LUL_LO 8'h16
`define TSRM_PTR_LLL_LO 8'h17
`define TSRM_PTR_RCRIT 8'h19
`define TSRM_PTR_PREC 8'h1a
`define TSRM_PTR_LCRIT 8'h20
`define TSRM_PTR_HYST 8'h21
`define TSRM_PTR_REPEAT 8'h22
`define TSRM_PTR_MAKER 8'hfe
`define TSRM_PTR_PART 8'hff
// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define TSRM_RST_PTR 8'h00
`define TSRM_RST_ZERO 8'h00
`define TSRM_RST_UPPER_HI 8'h55
`define TSRM_RST_CRIT 8'h55
`define TSRM_RST_HYST 8'h0a
`define TSRM_RST_RATE 8'h08
`define TSRM_RST_PREC 8'h1c
`define TSRM_RST_REPEAT 8'h81
`define TSRM_SETUP_MASK 8'he4
`define TSRM_RATE_MASK 8'h0f
`define TSRM_LOW_MASK 8'hf0
`define TSRM_PREC_MASK 8'h03
`define TSRM_REPEAT_MASK 8'h8e
`define TSRM_REPEAT_FIXED 8'h01
`define TSRM_SETUP_SD_BIT 6
`endif

// ### rtl/tsrm_pkg.sv
package tsrm_pkg;
    typedef enum logic [1:0] {
        TSRM_LIM_LU,
        TSRM_LIM_LL,
        TSRM_LIM_RU,
        TSRM_LIM_RL
    } tsrm_lim_t;
    typedef enum logic [1:0] {
        TSRM_ST_IDLE,
        TSRM_ST_PTR,
        TSRM_ST_WDATA,
        TSRM_ST_RDATA
    } tsrm_state_t;
endpackage

// ### rtl/tsrm_regs.sv
`timescale 1ns/1ps
`include "tsrm_consts.svh"
module tsrm_regs #(
    parameter logic [7:0] MAKER_CODE = 8'ha5, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h3c // arbitrary value
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    // byte-level slave port, decoded by the serial front end
    input wire logic start_in,
    input wire logic rnw_in,
    input wire logic wbyte_valid_in,
    input wire logic [7:0] wbyte_in,
    input wire logic rbyte_req_in,
    input wire logic stop_in,
    // conversion engine side
    input wire logic local_done_in,
    input wire logic [11:0] local_result_in,
    input wire logic remote_done_in,
    input wire logic [11:0] remote_result_in,
    input wire logic [7:0] flag_summary_in,
    output logic flag_read_out,
    output logic oneshot_out,
    output logic [7:0] rbyte_out,
    output logic rbyte_valid_out,
    output logic [7:0] pointer_out,
    output logic [7:0] setup_out,
    output logic [7:0] rate_out,
    output logic [7:0] precision_out,
    output logic [7:0] repeat_out,
    output logic [11:0] local_upper_out,
    output logic [11:0] local_lower_out,
    output logic [11:0] remote_upper_out,
    output logic [11:0] remote_lower_out,
    output logic [7:0] local_crit_out,
    output logic [7:0] remote_crit_out,
    output logic [7:0] hyst_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tsrm_pkg::tsrm_state_t st_r, st_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic [7:0] lim_hi_r [4];
    logic [7:0] lim_hi_nxt [4];
    logic [3:0] lim_lo_r [4];
    logic [3:0] lim_lo_nxt [4];
    logic [7:0] lt_hi_r, lt_hi_nxt, rt_hi_r, rt_hi_nxt;
    logic [3:0] lt_lo_r, lt_lo_nxt, rt_lo_r, rt_lo_nxt;
    logic [3:0] snap_r, snap_nxt;
    logic snap_ok_r, snap_ok_nxt;
    logic [7:0] setup_r, setup_nxt, rate_r, rate_nxt;
    logic [7:0] prec_r, prec_nxt, rep_r, rep_nxt;
    logic [7:0] lcrit_r, lcrit_nxt, rcrit_r, rcrit_nxt, hyst_r, hyst_nxt;
    logic [7:0] rbyte_r, rbyte_nxt;
    logic rvalid_r, rvalid_nxt;
    logic oneshot_r, oneshot_nxt;
    logic fread_r, fread_nxt;
    logic [1:0] wcnt_r, wcnt_nxt;
    logic [1:0] rcnt_r, rcnt_nxt;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [7:0] rd;
    logic [3:0] rd_snap;
    logic rd_snap_ld;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // byte index within a transaction: a second byte of a two-byte
    // access moves from a high-byte code to its low-byte partner
    function automatic logic [7:0] pair_lo(input logic [7:0] a);
        case (a)
            `TSRM_PTR_LT_HI: pair_lo = `TSRM_PTR_LT_LO;
            `TSRM_PTR_RT_HI: pair_lo = `TSRM_PTR_RT_LO;
            `TSRM_PTR_LUL_HI_RD, `TSRM_PTR_LUL_HI_WR: pair_lo = `TSRM_PTR_LUL_LO;
            `TSRM_PTR_LLL_HI_RD, `TSRM_PTR_LLL_HI_WR: pair_lo = `TSRM_PTR_LLL_LO;
            `TSRM_PTR_RUL_HI_RD, `TSRM_PTR_RUL_HI_WR: pair_lo = `TSRM_PTR_RUL_LO;
            `TSRM_PTR_RLL_HI_RD, `TSRM_PTR_RLL_HI_WR: pair_lo = `TSRM_PTR_RLL_LO;
            default: pair_lo = a;
        endcase
    endfunction

    always_comb begin
        ra = (rcnt_r == 2'd0) ? ptr_r : pair_lo(ptr_r);
        rd = 8'h00;
        rd_snap = snap_r;
        rd_snap_ld = 1'b0;
        case (ra)
            `TSRM_PTR_LT_HI: begin
                rd = lt_hi_r;
                rd_snap = lt_lo_r;
                rd_snap_ld = 1'b1;
            end
            `TSRM_PTR_RT_HI: begin
                rd = rt_hi_r;
                rd_snap = rt_lo_r;
                rd_snap_ld = 1'b1;
            end
            `TSRM_PTR_LT_LO: rd = {(snap_ok_r ? snap_r : lt_lo_r), 4'h0};
            `TSRM_PTR_RT_LO: rd = {(snap_ok_r ? snap_r : rt_lo_r), 4'h0};
            `TSRM_PTR_FLAGS: rd = flag_summary_in;
            `TSRM_PTR_SETUP_RD: rd = setup_r;
            `TSRM_PTR_RATE_RD: rd = rate_r;
            `TSRM_PTR_LUL_HI_RD: rd = lim_hi_r[tsrm_pkg::TSRM_LIM_LU];
            `TSRM_PTR_LLL_HI_RD: rd = lim_hi_r[tsrm_pkg::TSRM_LIM_LL];
            `TSRM_PTR_RUL_HI_RD: rd = lim_hi_r[tsrm_pkg::TSRM_LIM_RU];
            `TSRM_PTR_RLL_HI_RD: rd = lim_hi_r[tsrm_pkg::TSRM_LIM_RL];
            `TSRM_PTR_LUL_LO: rd = {lim_lo_r[tsrm_pkg::TSRM_LIM_LU], 4'h0};
            `TSRM_PTR_LLL_LO: rd = {lim_lo_r[tsrm_pkg::TSRM_LIM_LL], 4'h0};
            `TSRM_PTR_RUL_LO: rd = {lim_lo_r[tsrm_pkg::TSRM_LIM_RU], 4'h0};
            `TSRM_PTR_RLL_LO: rd = {lim_lo_r[tsrm_pkg::TSRM_LIM_RL], 4'h0};
            `TSRM_PTR_RCRIT: rd = rcrit_r;
            `TSRM_PTR_LCRIT: rd = lcrit_r;
            `TSRM_PTR_HYST: rd = hyst_r;
            `TSRM_PTR_PREC: rd = prec_r;
            `TSRM_PTR_REPEAT: rd = rep_r;
            `TSRM_PTR_MAKER: rd = MAKER_CODE;
            `TSRM_PTR_PART: rd = PART_CODE;
            default: rd = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // transaction sequencing and register writes
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        ptr_nxt = ptr_r;
        wcnt_nxt = wcnt_r;
        rcnt_nxt = rcnt_r;
        lim_hi_nxt = lim_hi_r;
        lim_lo_nxt = lim_lo_r;
        setup_nxt = setup_r;
        rate_nxt = rate_r;
        prec_nxt = prec_r;
        rep_nxt = rep_r;
        lcrit_nxt = lcrit_r;
        rcrit_nxt = rcrit_r;
        hyst_nxt = hyst_r;
        snap_nxt = snap_r;
        snap_ok_nxt = snap_ok_r;
        rbyte_nxt = rbyte_r;
        rvalid_nxt = 1'b0;
        oneshot_nxt = 1'b0;
        fread_nxt = 1'b0;
        wa = (wcnt_r == 2'd0) ? ptr_r : pair_lo(ptr_r);
        if (start_in) begin
            st_nxt = rnw_in ? tsrm_pkg::TSRM_ST_RDATA : tsrm_pkg::TSRM_ST_PTR;
            wcnt_nxt = 2'd0;
            rcnt_nxt = 2'd0;
        end else if (stop_in) begin
            st_nxt = tsrm_pkg::TSRM_ST_IDLE;
        end else begin
            case (st_r)
                tsrm_pkg::TSRM_ST_PTR: begin
                    if (wbyte_valid_in) begin
                        ptr_nxt = wbyte_in;
                        st_nxt = tsrm_pkg::TSRM_ST_WDATA;
                    end
                end
                tsrm_pkg::TSRM_ST_WDATA: begin
                    if (wbyte_valid_in && wcnt_r != 2'd2) begin
                        wcnt_nxt = wcnt_r + 2'd1;
                        // unmapped and read-only codes fall to default
                        case (wa)
                            `TSRM_PTR_LUL_HI_WR: lim_hi_nxt[tsrm_pkg::TSRM_LIM_LU] = wbyte_in;
                            `TSRM_PTR_LLL_HI_WR: lim_hi_nxt[tsrm_pkg::TSRM_LIM_LL] = wbyte_in;
                            `TSRM_PTR_RUL_HI_WR: lim_hi_nxt[tsrm_pkg::TSRM_LIM_RU] = wbyte_in;
                            `TSRM_PTR_RLL_HI_WR: lim_hi_nxt[tsrm_pkg::TSRM_LIM_RL] = wbyte_in;
                            `TSRM_PTR_LUL_LO: lim_lo_nxt[tsrm_pkg::TSRM_LIM_LU] = wbyte_in[7:4];
                            `TSRM_PTR_LLL_LO: lim_lo_nxt[tsrm_pkg::TSRM_LIM_LL] = wbyte_in[7:4];
                            `TSRM_PTR_RUL_LO: lim_lo_nxt[tsrm_pkg::TSRM_LIM_RU] = wbyte_in[7:4];
                            `TSRM_PTR_RLL_LO: lim_lo_nxt[tsrm_pkg::TSRM_LIM_RL] = wbyte_in[7:4];
                            // limits stay as stored across a range change
                            `TSRM_PTR_SETUP_WR: setup_nxt = wbyte_in & `TSRM_SETUP_MASK;
                            `TSRM_PTR_RATE_WR: rate_nxt = wbyte_in & `TSRM_RATE_MASK;
                            `TSRM_PTR_PREC: prec_nxt = (wbyte_in & `TSRM_PREC_MASK) |
                                (`TSRM_RST_PREC & ~`TSRM_PREC_MASK);
                            `TSRM_PTR_REPEAT: rep_nxt = (wbyte_in & `TSRM_REPEAT_MASK) |
                                `TSRM_REPEAT_FIXED;
                            `TSRM_PTR_RCRIT: rcrit_nxt = wbyte_in;
                            `TSRM_PTR_LCRIT: lcrit_nxt = wbyte_in;
                            `TSRM_PTR_HYST: hyst_nxt = wbyte_in;
                            // pulse only while shut down (setup SD bit set), data discarded
                            `TSRM_PTR_ONESHOT: oneshot_nxt = setup_r[`TSRM_SETUP_SD_BIT];
                            default: wcnt_nxt = wcnt_r + 2'd1;
                        endcase
                    end
                end
                tsrm_pkg::TSRM_ST_RDATA: begin
                    if (rbyte_req_in) begin
                        // pointer untouched by reads
                        rbyte_nxt = rd;
                        rvalid_nxt = 1'b1;
                        if (rcnt_r != 2'd2) begin
                            rcnt_nxt = rcnt_r + 2'd1;
                        end
                        fread_nxt = (ra == `TSRM_PTR_FLAGS);
                        if (rd_snap_ld) begin
                            snap_nxt = rd_snap;
                            snap_ok_nxt = 1'b1;
                        end else if (rcnt_r != 2'd1 || ra == ptr_r) begin
                            // any other read ends coherence, except the second byte of a two-byte pair read
                            snap_ok_nxt = 1'b0;
                        end
                    end
                end
                default: st_nxt = st_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // result capture
    // ------------------------------------------------------------
    always_comb begin
        lt_hi_nxt = lt_hi_r;
        lt_lo_nxt = lt_lo_r;
        rt_hi_nxt = rt_hi_r;
        rt_lo_nxt = rt_lo_r;
        if (local_done_in) begin
            lt_hi_nxt = local_result_in[11:4];
            lt_lo_nxt = local_result_in[3:0];
        end
        if (remote_done_in) begin
            rt_hi_nxt = remote_result_in[11:4];
            rt_lo_nxt = remote_result_in[3:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st_r <= tsrm_pkg::TSRM_ST_IDLE;
            ptr_r <= `TSRM_RST_PTR;
            wcnt_r <= 2'd0;
            rcnt_r <= 2'd0;
            lim_hi_r[tsrm_pkg::TSRM_LIM_LU] <= `TSRM_RST_UPPER_HI;
            lim_hi_r[tsrm_pkg::TSRM_LIM_RU] <= `TSRM_RST_UPPER_HI;
            lim_hi_r[tsrm_pkg::TSRM_LIM_LL] <= `TSRM_RST_ZERO;
            lim_hi_r[tsrm_pkg::TSRM_LIM_RL] <= `TSRM_RST_ZERO;
            for (int i = 0; i < 4; i++) begin
                lim_lo_r[i] <= 4'h0;
            end
            lt_hi_r <= `TSRM_RST_ZERO;
            rt_hi_r <= `TSRM_RST_ZERO;
            lt_lo_r <= 4'h0;
            rt_lo_r <= 4'h0;
            snap_r <= 4'h0;
            snap_ok_r <= 1'b0;
            setup_r <= `TSRM_RST_ZERO;
            rate_r <= `TSRM_RST_RATE;
            prec_r <= `TSRM_RST_PREC;
            rep_r <= `TSRM_RST_REPEAT;
            lcrit_r <= `TSRM_RST_CRIT;
            rcrit_r <= `TSRM_RST_CRIT;
            hyst_r <= `TSRM_RST_HYST;
            rbyte_r <= 8'h00;
            rvalid_r <= 1'b0;
            oneshot_r <= 1'b0;
            fread_r <= 1'b0;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
            ptr_r <= ptr_nxt;
            wcnt_r <= wcnt_nxt;
            rcnt_r <= rcnt_nxt;
            lim_hi_r <= lim_hi_nxt;
            lim_lo_r <= lim_lo_nxt;
            lt_hi_r <= lt_hi_nxt;
            rt_hi_r <= rt_hi_nxt;
            lt_lo_r <= lt_lo_nxt;
            rt_lo_r <= rt_lo_nxt;
            snap_r <= snap_nxt;
            snap_ok_r <= snap_ok_nxt;
            setup_r <= setup_nxt;
            rate_r <= rate_nxt;
            prec_r <= prec_nxt;
            rep_r <= rep_nxt;
            lcrit_r <= lcrit_nxt;
            rcrit_r <= rcrit_nxt;
            hyst_r <= hyst_nxt;
            rbyte_r <= rbyte_nxt;
            rvalid_r <= rvalid_nxt;
            oneshot_r <= oneshot_nxt;
            fread_r <= fread_nxt;
        end
    end

    assign rbyte_out = rbyte_r;
    assign rbyte_valid_out = rvalid_r;
    assign oneshot_out = oneshot_r;
    assign flag_read_out = fread_r;
    assign pointer_out = ptr_r;
    assign setup_out = setup_r;
    assign rate_out = rate_r;
    assign precision_out = prec_r;
    assign repeat_out = rep_r;
    assign local_upper_out = {lim_hi_r[tsrm_pkg::TSRM_LIM_LU], lim_lo_r[tsrm_pkg::TSRM_LIM_LU]};
    assign local_lower_out = {lim_hi_r[tsrm_pkg::TSRM_LIM_LL], lim_lo_r[tsrm_pkg::TSRM_LIM_LL]};
    assign remote_upper_out = {lim_hi_r[tsrm_pkg::TSRM_LIM_RU], lim_lo_r[tsrm_pkg::TSRM_LIM_RU]};
    assign remote_lower_out = {lim_hi_r[tsrm_pkg::TSRM_LIM_RL], lim_lo_r[tsrm_pkg::TSRM_LIM_RL]};
    assign local_crit_out = lcrit_r;
    assign remote_crit_out = rcrit_r;
    assign hyst_out = hyst_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    sequence s_ptr_byte;
        clk_en_in && !start_in && !stop_in && st_r == tsrm_pkg::TSRM_ST_PTR && wbyte_valid_in;
    endsequence
    sequence s_hi_read(logic [7:0] code);
        clk_en_in && !start_in && !stop_in && st_r == tsrm_pkg::TSRM_ST_RDATA
            && rbyte_req_in && ra == code;
    endsequence

    chk_ptr_load: assert property (s_ptr_byte |=> ptr_r == $past(wbyte_in))
        else $error("pointer not loaded from first write byte");
    chk_ptr_read_hold: assert property (st_r == tsrm_pkg::TSRM_ST_RDATA && !start_in
        |=> ptr_r == $past(ptr_r))
        else $error("pointer changed during read");
    chk_read_latency: assert property (clk_en_in && !start_in && !stop_in
        && st_r == tsrm_pkg::TSRM_ST_RDATA && rbyte_req_in |=> rvalid_r)
        else $error("read byte not answered next cycle");
    chk_lt_refresh: assert property (clk_en_in && local_done_in
        |=> lt_hi_r == $past(local_result_in[11:4]))
        else $error("local result not refreshed");
    chk_rt_refresh: assert property (clk_en_in && remote_done_in
        |=> rt_hi_r == $past(remote_result_in[11:4]))
        else $error("remote result not refreshed");
    chk_lt_coherent: assert property (s_hi_read(`TSRM_PTR_LT_HI)
        |=> snap_ok_r && snap_r == $past(lt_lo_r))
        else $error("local low byte not snapped");
    chk_rt_coherent: assert property (s_hi_read(`TSRM_PTR_RT_HI)
        |=> snap_ok_r && snap_r == $past(rt_lo_r))
        else $error("remote low byte not snapped");
    chk_oneshot_sd: assert property (oneshot_r |-> setup_r[`TSRM_SETUP_SD_BIT]
        || $past(setup_r[`TSRM_SETUP_SD_BIT]))
        else $error("one-shot outside shutdown");
    chk_crit_stable: assert property (!(st_r == tsrm_pkg::TSRM_ST_WDATA)
        |=> $stable(lcrit_r) && $stable(rcrit_r) && $stable(hyst_r))
        else $error("critical limits changed without write");
    chk_limit_hold: assert property (!(st_r == tsrm_pkg::TSRM_ST_WDATA)
        |=> $stable(local_upper_out) && $stable(remote_lower_out))
        else $error("limit changed without write");
endmodule // tsrm_regs

// ### tb/tsrm_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host model driving the byte-level slave port
// ----------------------------------------------------------------
module tsrm_host (
    input wire logic clock_in,
    output logic start_out = 1'b0,
    output logic rnw_out = 1'b0,
    output logic wbyte_valid_out = 1'b0,
    output logic [7:0] wbyte_out = 8'h00,
    output logic rbyte_req_out = 1'b0,
    output logic stop_out = 1'b0,
    input wire logic [7:0] rbyte_in,
    input wire logic rbyte_valid_in
);
    task automatic open_xfer(input logic rd);
        @(posedge clock_in);
        start_out <= 1'b1;
        rnw_out <= rd;
        @(posedge clock_in);
        start_out <= 1'b0;
    endtask

    task automatic close_xfer();
        stop_out <= 1'b1;
        @(posedge clock_in);
        stop_out <= 1'b0;
    endtask

    // pointer byte leads every write, data follows msb first
    task automatic wr(input logic [7:0] ptr, input logic [15:0] data, input int n);
        open_xfer(1'b0);
        wbyte_valid_out <= 1'b1;
        wbyte_out <= ptr;
        for (int i = 0; i < n; i++) begin
            @(posedge clock_in);
            wbyte_out <= data[15-8*i -: 8];
        end
        @(posedge clock_in);
        wbyte_valid_out <= 1'b0;
        // a released byte lane must not look like the last byte
        wbyte_out <= ~wbyte_out;
        close_xfer();
    endtask

    // reads use the pointer of the last write, or the reset pointer; callers load it first, except the first read after reset
    task automatic rd(input int n, output logic [15:0] q);
        open_xfer(1'b1);
        q = 16'h0000;
        for (int i = 0; i < n; i++) begin
            rbyte_req_out <= 1'b1;
            @(posedge clock_in);
            rbyte_req_out <= 1'b0;
            #1;
            q[15-8*i -: 8] = (rbyte_valid_in === 1'b1) ? rbyte_in : 8'hxx;
            @(posedge clock_in);
        end
        close_xfer();
    endtask
endmodule // tsrm_host

// ### tb/temp_sensor_register_map_tb.sv
`timescale 1ns/1ps
module temp_sensor_register_map_tb;
    localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
    localparam logic [7:0] PART = 8'hc3; // arbitrary value
    localparam logic [7:0] FLAGS = 8'h96;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic ldone = 1'b0, rdone = 1'b0;
    logic [11:0] lres = 12'h000, rres = 12'h000;
    logic start, rnw, wv, rreq, stop, oneshot, rvalid, fread;
    logic [7:0] setup, rate, prec, rep;
    int n_fr = 0;
    logic [7:0] wbyte, rbyte, ptr, lcrit, rcrit, hyst, hv;
    logic [11:0] lu, ll, ru, rl;
    logic [15:0] q;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int n_os = 0;
    logic [7:0] codes [22] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h10, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1a, 8'h20, 8'h21, 8'h22, 8'hfe, 8'hff};
    logic [7:0] rstv [22] = '{8'h00, 8'h00, FLAGS, 8'h00, 8'h08, 8'h55, 8'h00, 8'h55, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h1c, 8'h55, 8'h0a, 8'h81, MAKER, PART};
    logic [7:0] lwr [4] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e};
    logic [7:0] lrd [4] = '{8'h05, 8'h06, 8'h07, 8'h08};
    logic [7:0] llo [4] = '{8'h16, 8'h17, 8'h13, 8'h14};

    always #10 clock_in = ~clock_in;

    tsrm_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) tsrm_regs_inst (
        .clock_in(clock_in), .srst_in(srst_in), .clk_en_in(1'b1),
        .start_in(start), .rnw_in(rnw), .wbyte_valid_in(wv), .wbyte_in(wbyte),
        .rbyte_req_in(rreq), .stop_in(stop), .local_done_in(ldone),
        .local_result_in(lres), .remote_done_in(rdone), .remote_result_in(rres),
        .flag_summary_in(FLAGS), .flag_read_out(fread), .oneshot_out(oneshot),
        .rbyte_out(rbyte), .rbyte_valid_out(rvalid), .pointer_out(ptr), .setup_out(setup),
        .rate_out(rate), .precision_out(prec), .repeat_out(rep), .local_upper_out(lu),
        .local_lower_out(ll), .remote_upper_out(ru), .remote_lower_out(rl),
        .local_crit_out(lcrit), .remote_crit_out(rcrit), .hyst_out(hyst));

    tsrm_host tsrm_host_inst (
        .clock_in(clock_in), .start_out(start), .rnw_out(rnw), .wbyte_valid_out(wv),
        .wbyte_out(wbyte), .rbyte_req_out(rreq), .stop_out(stop),
        .rbyte_in(rbyte), .rbyte_valid_in(rvalid));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic rd_at(input logic [7:0] p, input int n);
        tsrm_host_inst.wr(p, 16'h0000, 0);
        tsrm_host_inst.rd(n, q);
    endtask

    // one conversion result, local or remote
    task automatic conv(input logic loc, input logic [11:0] r);
        @(posedge clock_in);
        lres <= loc ? r : lres;
        rres <= loc ? rres : r;
        ldone <= loc;
        rdone <= !loc;
        @(posedge clock_in);
        ldone <= 1'b0;
        rdone <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // monitors and hang guard
    // ----------------------------------------------------------------
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (oneshot === 1'b1) begin
            n_os <= n_os + 1;
        end
        if (fread === 1'b1) begin
            n_fr <= n_fr + 1;
        end
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        chk("pointer", 16'h0000, {8'h00, ptr});
        chk("local upper port", 16'h0550, {4'h0, lu});
        chk("remote upper port", 16'h0550, {4'h0, ru});
        chk("local lower port", 16'h0000, {4'h0, ll});
        chk("remote lower port", 16'h0000, {4'h0, rl});
        chk("crit ports", 16'h5555, {lcrit, rcrit});
        chk("hyst port", 16'h000a, {8'h00, hyst});
        chk("setup rate ports", 16'h0008, {setup, rate});
        chk("prec repeat ports", 16'h1c81, {prec, rep});
        tsrm_host_inst.rd(1, q);
        chk("first read", 16'h0000, q);
        for (int i = 0; i < 22; i++) begin
            rd_at(codes[i], 1);
            chk("reset value", {rstv[i], 8'h00}, q);
        end
        for (int i = 0; i < 4; i++) begin
            hv = 8'h60 | 8'(i);
            tsrm_host_inst.wr(lwr[i], {hv, 8'h9f}, 2);
            rd_at(lrd[i], 2);
            chk("limit pair", {hv, 8'h90}, q);
            tsrm_host_inst.wr(llo[i], 16'h3000, 1);
            rd_at(llo[i], 1);
            chk("limit low", 16'h3000, q);
            chk("limit port", {hv, 4'h3}, i == 0 ? lu : i == 1 ? ll : i == 2 ? ru : rl);
        end
        for (int i = 0; i < 3; i++) begin
            hv = 8'h7e - 8'(i * 17);
            tsrm_host_inst.wr(i == 0 ? 8'h20 : i == 1 ? 8'h19 : 8'h21, {hv, 8'h00}, 1);
            tsrm_host_inst.rd(1, q);
            chk("crit or hyst", {hv, 8'h00}, q);
        end
        chk("crit ports", 16'h7e6d, {lcrit, rcrit});
        chk("hyst port", 16'h005c, {8'h00, hyst});
        tsrm_host_inst.wr(8'h00, 16'h7700, 1);
        tsrm_host_inst.wr(8'h05, 16'h1100, 1);
        tsrm_host_inst.wr(8'h30, 16'h2200, 1);
        chk("pointer kept", 16'h0030, {8'h00, ptr});
        chk("limit untouched", 16'h0603, {4'h0, lu});
        rd_at(8'h00, 1);
        chk("result untouched", 16'h0000, q);
        conv(1'b1, 12'h5a3);
        rd_at(8'h00, 1);
        chk("local high", 16'h5a00, q);
        conv(1'b1, 12'h6b7);
        rd_at(8'h15, 1);
        chk("snapped low", 16'h3000, q);
        rd_at(8'h00, 1);
        conv(1'b1, 12'h6c2);
        rd_at(8'h03, 1);
        rd_at(8'h15, 1);
        chk("fresh low", 16'h2000, q);
        conv(1'b0, 12'h4e9);
        rd_at(8'h01, 2);
        chk("remote pair", 16'h4e90, q);
        tsrm_host_inst.rd(2, q);
        chk("repeat read", 16'h4e90, q);
        tsrm_host_inst.wr(8'h0f, 16'hff00, 1);
        @(posedge clock_in);
        chk("one-shot running", 16'h0000, 16'(n_os));
        tsrm_host_inst.wr(8'h09, 16'hff00, 1);
        rd_at(8'h03, 1);
        chk("setup", 16'he400, q);
        chk("setup port", 16'h00e4, {8'h00, setup});
        chk("local range change", 16'h0603, {4'h0, lu});
        chk("remote range change", 16'h0623, {4'h0, ru});
        tsrm_host_inst.wr(8'h0a, 16'hff00, 1);
        tsrm_host_inst.wr(8'h1a, 16'hff00, 1);
        tsrm_host_inst.wr(8'h22, 16'hff00, 1);
        chk("rate prec ports", 16'h0f1f, {rate, prec});
        chk("repeat port", 16'h008f, {8'h00, rep});
        rd_at(8'h1a, 1);
        chk("prec read", 16'h1f00, q);
        tsrm_host_inst.wr(8'h0f, 16'h5500, 1);
        @(posedge clock_in);
        chk("one-shot shutdown", 16'h0001, 16'(n_os));
        chk("status read pulses", 16'h0001, 16'(n_fr));
        finish_test();
    end
endmodule // temp_sensor_register_map_tb
